// ===== local_event.sv
// one local event comparator with hysteresis
`timescale 1ns/10ps
`include "seq_map.svh"
module local_event (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic enable_i,
	input wire logic [6:0] local_event_type_i,
	input wire logic signed [15:0] local_event_setpoint_i,
	input wire logic signed [15:0] hys_abs_i,
	input wire logic signed [15:0] pv_i,
	input wire logic signed [15:0] sp_i,
	input wire logic signed [15:0] tsp_i,
	input wire logic signed [15:0] out_i,
	input wire logic signed [15:0] cool_i,
	output logic event_o
);
	logic active_ff;
	logic [6:0] kind;
	logic deen;
	logic signed [16:0] val;
	logic signed [16:0] dev;
	logic signed [16:0] hi;
	logic signed [16:0] lo;
	logic nxt_active;

	always_comb begin
		deen = (local_event_type_i > `LEV_DEEN_OFS);
		kind = deen ? 7'(local_event_type_i - `LEV_DEEN_OFS) : local_event_type_i;
		dev = 17'(pv_i) - 17'(sp_i);
		case (kind)
			7'h01: val = 17'(pv_i);
			7'h02: val = 17'(pv_i);
			7'h03, 7'h04: val = 17'(sp_i);
			7'h09, 7'h0A: val = 17'(tsp_i);
			7'h0B, 7'h0C, 7'h0D, 7'h0E: val = 17'(pv_i) - 17'(tsp_i);
			7'h0F, 7'h10: val = 17'(out_i);
			7'h11, 7'h12: val = 17'(cool_i);
			default: val = dev;
		endcase
		hi = 17'(local_event_setpoint_i);
		lo = -17'(local_event_setpoint_i);
		nxt_active = active_ff;
		// hysteresis band: set past setpoint, clear once back by the band
		case (kind)
			7'h01, 7'h03, 7'h05, 7'h09, 7'h0B, 7'h0F, 7'h11:
				nxt_active = active_ff ? (val > hi - 17'(hys_abs_i)) : (val > hi); // R09 R12
			7'h02, 7'h04, 7'h06, 7'h0A, 7'h0C, 7'h10, 7'h12:
				nxt_active = active_ff ? (val < hi + 17'(hys_abs_i)) : (val < hi); // R09 R12
			7'h07, 7'h0D:
				nxt_active = active_ff ? (val > hi - 17'(hys_abs_i) || val < lo + 17'(hys_abs_i))
					: (val > hi || val < lo);
			7'h08, 7'h0E:
				nxt_active = active_ff ? (val <= hi + 17'(hys_abs_i) && val >= lo - 17'(hys_abs_i))
					: (val <= hi && val >= lo);
			default: nxt_active = 1'b0; // R10
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i || !enable_i) begin
			active_ff <= 1'b0; // R08
		end else begin
			active_ff <= nxt_active; // R09
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i || !enable_i || kind == `LEV_TYPE_NONE || kind > `LEV_TYPE_MAX) begin
			event_o <= 1'b0; // R08 R10
		end else begin
			event_o <= nxt_active ^ deen; // R10
		end
	end
endmodule : local_event

// ===== program_segment_event_sequencer_test.sv
// self-checking bench of the segment sequencer over its bus and release pins
`timescale 1ns/10ps
`include "seq_map.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
	$display("[FAIL] %s expected %0h seen %0h", nm, ex, got); n_errors++; end end
`define WAITC(c) for (k = 0; k < 400 && !(c); k++) begin @(posedge sys_clk_i); #1; end
module program_segment_event_sequencer_test;
	localparam int TICK = 8;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata, v;
	logic hreadyout, hresp, rel_key, rel_contact, hold_lamp, load_sp, chain_req;
	logic [3:0] time_ev;
	logic [1:0] local_ev;
	logic [2:0] chain_pat;
	int n_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int k, i;

	initial begin
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	seq_top #(.TICK_CYCLES(TICK)) uut (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hsel_i(hsel),
		.hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
		.release_key_i(rel_key), .release_contact_i(rel_contact), .time_event_o(time_ev),
		.local_event_o(local_ev), .hold_lamp_o(hold_lamp), .load_start_sp_o(load_sp),
		.chain_pattern_o(chain_pat), .chain_req_o(chain_req)
	);
	seq_far_side far (.sys_clk_i(sys_clk_i), .release_key_o(rel_key),
		.release_contact_o(rel_contact));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up

	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		hsel <= 1'b1;
		@(posedge sys_clk_i);
		while (hreadyout !== 1'b1) @(posedge sys_clk_i);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge sys_clk_i);
		while (hreadyout !== 1'b1) @(posedge sys_clk_i);
		v = hrdata;
		#1;
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [31:0] a);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd

	task automatic wait_sec(input int n);
		rd(`ADDR_SEG_DUR);
		while (v < n) rd(`ADDR_SEG_DUR);
	endtask : wait_sec

	// event 3 always starts on, so a missed clear shows wherever a scenario checks time_ev off
	task automatic go(input logic [3:0] code, input logic [7:0] ofs, input logic [31:0] ctrl);
		wr(`ADDR_SEG_CFG, {16'h0000, ofs, 4'h8, code});
		wr(`ADDR_CTRL, 32'h0000_0000);
		wr(`ADDR_CTRL, ctrl);
	endtask : go
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			wrap_up();
		end
	end

	initial begin
		repeat (20) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(`ADDR_STATUS);
		`CHK("status", 32'h0000_0100, v)
		`CHK("outputs", 9'h000, {time_ev, local_ev, hold_lamp, load_sp, chain_req})
		rd(32'h0000_0030);
		`CHK("unmapped", 32'h0000_0000, v)
		// 12 s segment: ev0 3..6, ev1 on equals off, ev2 past the end, ev3 no times
		wr(`ADDR_SEG_DUR, 32'h0000_000C);
		wr(`ADDR_TEV_TIME, 32'h0006_0003);
		wr(`ADDR_TEV_TIME + 4, 32'h0004_0004);
		wr(`ADDR_TEV_TIME + 8, {`TIME_NONE, 16'h0014});
		wr(`ADDR_TEV_TIME + 12, {`TIME_NONE, `TIME_NONE});
		go(4'h0, 8'h00, 32'h0000_0041);
		wait_sec(5);
		`CHK("tev", 4'b1001, time_ev)
		wait_sec(8);
		`CHK("tev", 4'b1000, time_ev)
		`WAITC(load_sp === 1'b1)
		`CHK("load_sp", 1'b1, load_sp)
		rd(`ADDR_STATUS);
		`CHK("status", 32'h0000_0100, v)
		go(4'h0, 8'h04, 32'h0000_0061);
		rd(`ADDR_STATUS);
		`CHK("tev", 4'b1001, time_ev)
		wr(`ADDR_CTRL, 32'h0000_0000);
		rd(`ADDR_STATUS);
		`CHK("tev", 4'b0000, time_ev)
		// hours.minutes: the 0.03 on time is three minutes away
		go(4'h0, 8'h00, 32'h0000_0051);
		wait_sec(5);
		`CHK("tev", 4'b1000, time_ev)
		for (i = 0; i < 3; i++) begin
			go(4'h1, 8'h00, 32'h0000_0041);
			`WAITC(hold_lamp === 1'b1)
			repeat (40) @(posedge sys_clk_i);
			#1;
			`CHK("lamp", 1'b1, hold_lamp)
			if (i == 2) wr(`ADDR_CTRL, 32'h0000_0049);
			else far.press(i[0]);
			`WAITC(hold_lamp === 1'b0)
			`CHK("lamp", 1'b0, hold_lamp)
			rd(`ADDR_STATUS);
			if (i < 2) `CHK("status", 32'h0000_0100, v)
		end
		for (i = 6; i < 10; i++) begin
			go(i[3:0], 8'h00, 32'h0000_00C1);
			`WAITC(chain_req === 1'b1)
			`CHK("chain", {1'b1, 3'(i - 5)}, {chain_req, chain_pat})
		end
		// local after release: waits at the end, bus release enters local
		go(4'h5, 8'h00, 32'h0000_0041);
		repeat (14 * TICK) @(posedge sys_clk_i);
		rd(`ADDR_STATUS);
		`CHK("state", 5'b10000, v[12:8])
		wr(`ADDR_CTRL, 32'h0000_0045);
		rd(`ADDR_STATUS);
		`CHK("state", 5'b01000, v[12:8])
		// local event 0: pv high limit at 100, pv 200
		wr(`ADDR_LEV_CFG, 32'h0064_0001);
		wr(`ADDR_PROC, 32'h0000_00C8);
		go(4'h2, 8'h00, 32'h0000_0001);
		repeat (14 * TICK) @(posedge sys_clk_i);
		rd(`ADDR_STATUS);
		`CHK("state", 5'b00010, v[12:8])
		`CHK("lev", 2'b00, local_ev)
		wr(`ADDR_CTRL, 32'h0000_0041);
		`WAITC(local_ev[0] === 1'b1)
		rd(`ADDR_STATUS);
		`CHK("state", 5'b01000, v[12:8])
		`CHK("lev", 2'b01, local_ev)
		`CHK("tev", 4'b0000, time_ev)
		wr(`ADDR_PROC, 32'h0000_0032);
		rd(`ADDR_STATUS);
		`CHK("lev", 2'b00, local_ev)
		wr(`ADDR_LEV_CFG, 32'h0064_0065);
		rd(`ADDR_STATUS);
		`CHK("lev", 2'b01, local_ev)
		wrap_up();
	end
endmodule : program_segment_event_sequencer_test

// ===== seq_far_side.sv
// far-side model: front key and contact input that release a held program
`timescale 1ns/10ps
module seq_far_side (
	input wire logic sys_clk_i,
	output logic release_key_o,
	output logic release_contact_o
);
	initial begin
		release_key_o = 1'b0;
		release_contact_o = 1'b0;
	end
	// held several cycles so the input filter sees a clean level
	task automatic press(input logic contact);
		@(posedge sys_clk_i);
		if (contact) release_contact_o <= 1'b1;
		else release_key_o <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
		release_key_o <= 1'b0;
		release_contact_o <= 1'b0;
	endtask : press
endmodule : seq_far_side

// ===== seq_map.svh
// register map, field layout and timing constants of the segment sequencer
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH

`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_SEG_DUR 8'h08
`define ADDR_SEG_CFG 8'h0C
`define ADDR_TEV_TIME 8'h10
`define ADDR_LEV_CFG 8'h20
`define ADDR_PROC 8'h28
`define ADDR_LEV_SPAN 8'h2C

`define CTRL_RUN_BIT 0
`define CTRL_LOCAL_BIT 1
`define CTRL_RELEASE_BIT 2
`define CTRL_ADVANCE_BIT 3
`define CTRL_UNIT_BIT 4
`define CTRL_MIDSTART_BIT 5
`define CTRL_LAST_BIT 6
`define CTRL_PATOPT_BIT 7

`define CODE_W 4
`define SEGCFG_CODE_LSB 0
`define SEGCFG_START_LSB 4
`define SEGCFG_START_OFS_LSB 8

`define TIME_W 16
`define TIME_NONE 16'hFFFF
`define TIME_MAX_MIN 16'hEA5F
`define TICK_NS 1000
`define CLK_NS 4
`define TICK_CYCLES ((`TICK_NS + `CLK_NS - 1) / `CLK_NS)
`define SEC_PER_MIN 60

`define LEV_TYPE_NONE 7'h00
`define LEV_TYPE_MAX 7'h12
`define LEV_DEEN_OFS 7'h64
`define LEV_SP_MAX 16'sh7530
`define HYS_MAX 10'h3E8

`endif

// ===== seq_pkg.sv
// types of the segment sequencer
package seq_pkg;
	typedef enum logic [3:0] {
		CODE_PROCEED_NEXT = 4'h0,
		CODE_HOLD = 4'h1,
		CODE_SWITCH_TO_LOCAL = 4'h2,
		CODE_WAIT_AT_SWITCHING = 4'h3,
		CODE_WAIT_IN_INTERVAL = 4'h4,
		CODE_LOCAL_AFTER_RELEASE = 4'h5,
		CODE_PATTERN_CHAIN_1 = 4'h6,
		CODE_PATTERN_CHAIN_2 = 4'h7,
		CODE_PATTERN_CHAIN_3 = 4'h8,
		CODE_PATTERN_CHAIN_4 = 4'h9,
		CODE_SEGMENT_INSERT = 4'hA,
		CODE_SEGMENT_DELETE = 4'hB
	} end_code_t;

	typedef enum logic [4:0] {
		ST_RESET = 5'b00001,
		ST_RUN = 5'b00010,
		ST_SUSPEND = 5'b00100,
		ST_LOCAL = 5'b01000,
		ST_WAIT_LOCAL = 5'b10000
	} seq_state_t;
endpackage : seq_pkg

// ===== seq_top.sv
// program segment sequencer with time and local events behind an AHB-Lite slave
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "seq_map.svh"

// Summary of operation
// R01: a mid-segment start presets time events as if the segment ran from its start.
// R02: each of four time events starts a segment either on or off.
// R03: on and off times are unregistered or 0.01 to 999.59 in the program unit; code accepts up to 234.59 only.
// R04: an on or off time beyond the segment duration causes no transition.
// R05: leaving program operation forces every time event off.
// R06: one unit setting reads times as hours.minutes or minutes.seconds.
// R07: coinciding on and off times in a segment resolve to off.
// R08: local events are evaluated only in local operation, else inactive.
// R09: local events have no stand-by or latch, follow comparison with hysteresis.
// R10: local event type is off or 1 to 18, plus 100 inverts polarity.
// R11: local event setpoint is signed with an upper bound of 30000.
// R12: hysteresis is 0.0 to 100.0 percent of span.
// R13: every segment carries its own end code.
// R14: end codes: continue, hold, local, waits, local after release, links, edits; code treats waits and edits as continue.
// R15: pattern chains reach patterns 1 or 2, or 1 to 4 with the option.
// R16: continue on a middle segment proceeds into the next segment.
// R17: continue on the last segment stops into reset.
// R18: continue on the last segment loads start setpoint as target.
// R19: hold code suspends at segment end and lights hold while suspended.
// R20: suspension lasts until a key or contact release arrives.
// R21: releasing a hold on the last segment stops into reset.
// R22: segment advance while suspended clears the suspension.
// R23: time events are off at program end, local start and in reset.
// R24: switch to local acts only on the last segment, else as continue.
// R25: segment elapsed time advances from one timebase tick.
module seq_top #(
	parameter int TEV_N = 4,
	parameter int LEV_N = 2,
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hsel_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic release_key_i,
	input wire logic release_contact_i,
	output logic [TEV_N-1:0] time_event_o,
	output logic [LEV_N-1:0] local_event_o,
	output logic hold_lamp_o,
	output logic load_start_sp_o,
	output logic [2:0] chain_pattern_o,
	output logic chain_req_o
);
	generate
		if (TEV_N != 4 || LEV_N != 2 || TICK_CYCLES < 1) begin : g_param_check
			$error("seq_top: unsupported parameter values");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// bus slave
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic [7:0] ctrl_ff;
	logic [15:0] seg_dur_ff;
	logic [15:0] seg_cfg_ff;
	logic [31:0] tev_time_ff [TEV_N];
	logic [31:0] lev_cfg_ff [LEV_N];
	logic [31:0] proc_ff;
	logic [15:0] lev_span_ff;
	logic cmd_release;
	logic cmd_advance;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else if (hready_i) begin
			wr_pend_ff <= hsel_i && htrans_i[1] && hwrite_i;
			wr_addr_ff <= haddr_i[7:0];
		end
	end

	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign cmd_release = wr_pend_ff && wr_addr_ff == `ADDR_CTRL && hwdata_i[`CTRL_RELEASE_BIT];
	assign cmd_advance = wr_pend_ff && wr_addr_ff == `ADDR_CTRL && hwdata_i[`CTRL_ADVANCE_BIT];

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ctrl_ff <= 8'h00;
			seg_dur_ff <= 16'h0000;
			seg_cfg_ff <= 16'h0000;
			proc_ff <= 32'h0000_0000;
			lev_span_ff <= 16'h0000;
		end else if (wr_pend_ff) begin
			case (wr_addr_ff)
				`ADDR_CTRL: ctrl_ff <= hwdata_i[7:0] & 8'hF3;
				`ADDR_SEG_DUR: seg_dur_ff <= hwdata_i[15:0];
				`ADDR_SEG_CFG: seg_cfg_ff <= hwdata_i[15:0]; // R13
				`ADDR_PROC: proc_ff <= hwdata_i;
				`ADDR_LEV_SPAN: lev_span_ff <= hwdata_i[15:0];
				default: ;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < TEV_N; g++) begin : g_tev_reg
			always_ff @(posedge sys_clk_i) begin
				if (reset_i) begin
					tev_time_ff[g] <= {`TIME_NONE, `TIME_NONE};
				end else if (wr_pend_ff && wr_addr_ff == 8'(`ADDR_TEV_TIME + 4 * g)) begin
					tev_time_ff[g] <= hwdata_i; // R03
				end
			end
		end
		for (g = 0; g < LEV_N; g++) begin : g_lev_reg
			always_ff @(posedge sys_clk_i) begin
				if (reset_i) begin
					lev_cfg_ff[g] <= 32'h0000_0000;
				end else if (wr_pend_ff && wr_addr_ff == 8'(`ADDR_LEV_CFG + 4 * g)) begin
					lev_cfg_ff[g] <= hwdata_i;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// release inputs from pins: three flops, second and third agree
	logic [2:0] rel_key_sync_ff;
	logic [2:0] rel_con_sync_ff;
	logic rel_level_ff;
	logic pin_release;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rel_key_sync_ff <= 3'b000;
			rel_con_sync_ff <= 3'b000;
		end else begin
			rel_key_sync_ff <= {rel_key_sync_ff[1:0], release_key_i};
			rel_con_sync_ff <= {rel_con_sync_ff[1:0], release_contact_i};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rel_level_ff <= 1'b0;
		end else if (rel_key_sync_ff[1] == rel_key_sync_ff[2]
			&& rel_con_sync_ff[1] == rel_con_sync_ff[2]) begin
			rel_level_ff <= rel_key_sync_ff[2] | rel_con_sync_ff[2];
		end
	end

	assign pin_release = (rel_key_sync_ff[1] == rel_key_sync_ff[2]
		&& rel_con_sync_ff[1] == rel_con_sync_ff[2]
		&& (rel_key_sync_ff[2] | rel_con_sync_ff[2]) && !rel_level_ff); // R20

	////////////////////////////////////////////////////////////////////////////////
	// timebase and segment timer, counted in seconds
	localparam int TB_W = $clog2(TICK_CYCLES + 1);
	logic [TB_W-1:0] tb_cnt_ff;
	logic tick;
	logic [23:0] elapsed_ff;
	logic [23:0] seg_len;
	logic seg_done;
	logic [23:0] start_ofs;

	// converts a two-field time to base seconds; hours.minutes unit multiplies by 60
	function automatic logic [23:0] to_secs(input logic [15:0] t, input logic unit_hm);
		logic [23:0] s;
		s = 24'(t[15:8]) * 24'(`SEC_PER_MIN) + 24'(t[7:0]);
		to_secs = unit_hm ? 24'(s * 24'(`SEC_PER_MIN)) : s; // R06
	endfunction : to_secs

	// a time is usable when registered, in range and inside the segment
	function automatic logic time_valid(input logic [15:0] t, input logic [23:0] len,
		input logic unit_hm);
		time_valid = (t != `TIME_NONE) && (t[7:0] < 8'(`SEC_PER_MIN))
			&& (t != 16'h0000) && (t <= `TIME_MAX_MIN) && (to_secs(t, unit_hm) <= len); // R03 R04
	endfunction : time_valid

	assign seg_len = to_secs(seg_dur_ff, ctrl_ff[`CTRL_UNIT_BIT]);
	assign start_ofs = ctrl_ff[`CTRL_MIDSTART_BIT]
		? to_secs({8'h00, seg_cfg_ff[15:`SEGCFG_START_OFS_LSB]}, ctrl_ff[`CTRL_UNIT_BIT])
		: 24'h00_0000;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i || tb_cnt_ff == TB_W'(TICK_CYCLES - 1)) begin
			tb_cnt_ff <= '0;
		end else begin
			tb_cnt_ff <= tb_cnt_ff + 1'b1;
		end
	end
	assign tick = (tb_cnt_ff == TB_W'(TICK_CYCLES - 1)); // R25

	////////////////////////////////////////////////////////////////////////////////
	// sequencer
	seq_pkg::seq_state_t state_ff;
	seq_pkg::seq_state_t nxt_state;
	seq_pkg::end_code_t code;
	logic is_last;
	logic run_prev_ff;
	logic seg_start;
	logic go_reset;
	logic end_local;
	logic replay;

	assign code = seq_pkg::end_code_t'(seg_cfg_ff[`SEGCFG_CODE_LSB +: `CODE_W]);
	assign is_last = ctrl_ff[`CTRL_LAST_BIT];
	assign seg_done = (state_ff == seq_pkg::ST_RUN) && tick && (elapsed_ff + 24'h00_0001 >= seg_len);
	assign end_local = is_last && (code == seq_pkg::CODE_SWITCH_TO_LOCAL); // R24

	always_comb begin
		nxt_state = state_ff;
		go_reset = 1'b0;
		case (state_ff)
			seq_pkg::ST_RESET: begin
				if (ctrl_ff[`CTRL_RUN_BIT] && !run_prev_ff) begin
					nxt_state = seq_pkg::ST_RUN;
				end else if (ctrl_ff[`CTRL_LOCAL_BIT]) begin
					nxt_state = seq_pkg::ST_LOCAL;
				end
			end
			seq_pkg::ST_RUN: begin
				if (!ctrl_ff[`CTRL_RUN_BIT]) begin
					nxt_state = ctrl_ff[`CTRL_LOCAL_BIT] ? seq_pkg::ST_LOCAL : seq_pkg::ST_RESET;
				end else if (seg_done) begin
					case (code)
						seq_pkg::CODE_HOLD: nxt_state = seq_pkg::ST_SUSPEND; // R19
						seq_pkg::CODE_LOCAL_AFTER_RELEASE:
							nxt_state = is_last ? seq_pkg::ST_WAIT_LOCAL : seq_pkg::ST_RUN;
						default: begin
							if (end_local) begin
								nxt_state = seq_pkg::ST_LOCAL;
							end else if (is_last) begin
								nxt_state = seq_pkg::ST_RESET; // R17
								go_reset = 1'b1;
							end
						end
					endcase
				end
			end
			seq_pkg::ST_SUSPEND, seq_pkg::ST_WAIT_LOCAL: begin
				if (pin_release || cmd_release || cmd_advance) begin // R20 R22
					if (state_ff == seq_pkg::ST_WAIT_LOCAL) begin
						nxt_state = seq_pkg::ST_LOCAL;
					end else if (is_last) begin
						nxt_state = seq_pkg::ST_RESET; // R21
					end else begin
						nxt_state = seq_pkg::ST_RUN;
					end
				end
			end
			seq_pkg::ST_LOCAL: begin
				// local reached from a program end stays until run is dropped too
				if (!ctrl_ff[`CTRL_LOCAL_BIT] && !ctrl_ff[`CTRL_RUN_BIT]) begin
					nxt_state = seq_pkg::ST_RESET;
				end
			end
			default: nxt_state = seq_pkg::ST_RESET;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state_ff <= seq_pkg::ST_RESET;
			run_prev_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			run_prev_ff <= ctrl_ff[`CTRL_RUN_BIT];
		end
	end

	// new segment begins at start, after a proceed, or after a released mid-program hold
	assign seg_start = (nxt_state == seq_pkg::ST_RUN)
		&& (state_ff != seq_pkg::ST_RUN || seg_done);
	// only a start out of reset replays edges; later segments begin at their start state
	assign replay = (state_ff == seq_pkg::ST_RESET); // R01

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			elapsed_ff <= 24'h00_0000;
		end else if (seg_start) begin
			elapsed_ff <= (state_ff == seq_pkg::ST_RESET) ? start_ofs : 24'h00_0000; // R01
		end else if (state_ff == seq_pkg::ST_RUN && tick) begin
			elapsed_ff <= elapsed_ff + 24'h00_0001; // R25 R16
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			hold_lamp_o <= 1'b0;
			load_start_sp_o <= 1'b0;
			chain_req_o <= 1'b0;
			chain_pattern_o <= 3'h0;
		end else begin
			hold_lamp_o <= (nxt_state == seq_pkg::ST_SUSPEND); // R19
			load_start_sp_o <= go_reset; // R18
			chain_req_o <= seg_done && code >= seq_pkg::CODE_PATTERN_CHAIN_1
				&& (code <= seq_pkg::CODE_PATTERN_CHAIN_2 || (ctrl_ff[`CTRL_PATOPT_BIT]
				&& code <= seq_pkg::CODE_PATTERN_CHAIN_4)); // R15 R14
			chain_pattern_o <= 3'(code - seq_pkg::CODE_PATTERN_CHAIN_1) + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// time events
	generate
		for (g = 0; g < TEV_N; g++) begin : g_tev
			logic [15:0] on_t;
			logic [15:0] off_t;
			logic [23:0] on_s;
			logic [23:0] off_s;
			logic on_ok;
			logic off_ok;
			logic pre;
			assign on_t = tev_time_ff[g][15:0];
			assign off_t = tev_time_ff[g][31:16];
			assign on_s = to_secs(on_t, ctrl_ff[`CTRL_UNIT_BIT]);
			assign off_s = to_secs(off_t, ctrl_ff[`CTRL_UNIT_BIT]);
			assign on_ok = time_valid(on_t, seg_len, ctrl_ff[`CTRL_UNIT_BIT]);
			assign off_ok = time_valid(off_t, seg_len, ctrl_ff[`CTRL_UNIT_BIT]);

			// replays the edges that lie before the mid-segment start point
			always_comb begin
				pre = seg_cfg_ff[`SEGCFG_START_LSB + g]; // R02
				if (replay && on_ok && on_s <= start_ofs
					&& (!off_ok || off_s > start_ofs || off_s < on_s)) begin
					pre = 1'b1; // R01
				end
				if (replay && off_ok && off_s <= start_ofs
					&& (!on_ok || on_s > start_ofs || on_s <= off_s)) begin
					pre = 1'b0; // R01 R07
				end
			end

			always_ff @(posedge sys_clk_i) begin
				if (reset_i || nxt_state != seq_pkg::ST_RUN && nxt_state != seq_pkg::ST_SUSPEND) begin
					time_event_o[g] <= 1'b0; // R05 R23
				end else if (seg_start) begin
					time_event_o[g] <= pre; // R02 R01
				end else if (state_ff == seq_pkg::ST_RUN && tick) begin
					if (off_ok && off_s == elapsed_ff + 24'h00_0001) begin
						time_event_o[g] <= 1'b0; // R07 R04
					end else if (on_ok && on_s == elapsed_ff + 24'h00_0001) begin
						time_event_o[g] <= 1'b1; // R04
					end
				end
			end
		end

		////////////////////////////////////////////////////////////////////////////
		// local events
		for (g = 0; g < LEV_N; g++) begin : g_lev
			logic signed [15:0] sp_lim;
			logic [9:0] hys;
			logic signed [15:0] hys_abs;
			assign sp_lim = ($signed(lev_cfg_ff[g][31:16]) > `LEV_SP_MAX) ? `LEV_SP_MAX
				: $signed(lev_cfg_ff[g][31:16]); // R11
			assign hys = (lev_cfg_ff[g][16 - 1 -: 10] > `HYS_MAX) ? `HYS_MAX
				: lev_cfg_ff[g][16 - 1 -: 10]; // R12
			assign hys_abs = 16'((32'(lev_span_ff) * 32'(hys)) / 32'(`HYS_MAX)); // R12
			local_event u_lev (
				.sys_clk_i(sys_clk_i),
				.reset_i(reset_i),
				.enable_i(state_ff == seq_pkg::ST_LOCAL), // R08
				.local_event_type_i(lev_cfg_ff[g][6:0]),
				.local_event_setpoint_i(sp_lim),
				.hys_abs_i(hys_abs),
				.pv_i(proc_ff[15:0]),
				.sp_i(proc_ff[31:16]),
				.tsp_i(proc_ff[31:16]),
				.out_i(proc_ff[15:0]),
				.cool_i(proc_ff[15:0]),
				.event_o(local_event_o[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// read data
	always_comb begin
		case (wr_addr_ff)
			`ADDR_CTRL: hrdata_o = {24'h00_0000, ctrl_ff};
			`ADDR_STATUS: hrdata_o = {16'h0000, 3'h0, state_ff, 2'h0, local_event_o, time_event_o};
			`ADDR_SEG_DUR: hrdata_o = {8'h00, elapsed_ff};
			`ADDR_SEG_CFG: hrdata_o = {16'h0000, seg_cfg_ff};
			`ADDR_PROC: hrdata_o = proc_ff;
			default: hrdata_o = 32'h0000_0000;
		endcase
	end
endmodule : seq_top

// ===== seq_top_assertions.sv
// port assertions of the segment sequencer
`timescale 1ns/10ps
module seq_top_checker #(
	parameter int TEV_N = 4,
	parameter int LEV_N = 2,
	parameter int TICK_CYCLES = 2
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hsel_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic release_key_i,
	input wire logic release_contact_i,
	input wire logic [TEV_N-1:0] time_event_o,
	input wire logic [LEV_N-1:0] local_event_o,
	input wire logic hold_lamp_o,
	input wire logic load_start_sp_o,
	input wire logic [2:0] chain_pattern_o,
	input wire logic chain_req_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	////////////////////////////////////////////////////////////////////////////////
	// cycles since the last release or bus access; a hold may only end shortly after one
	logic [3:0] quiet_ff;
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || release_key_i || release_contact_i || (hsel_i && htrans_i[1])) begin
			quiet_ff <= 4'h0;
		end else if (quiet_ff != 4'hF) begin
			quiet_ff <= quiet_ff + 4'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_ready;
		hreadyout_o == 1'b1;
	endproperty
	a_ready: assert property (p_ready) else $error("hreadyout dropped");
	property p_okay;
		hresp_o == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_unmapped;
		hsel_i && htrans_i[1] && hready_i && !hwrite_i && haddr_i == 32'h0000_0030
			|=> hrdata_o == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_load_pulse;
		load_start_sp_o |=> !load_start_sp_o;
	endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("start setpoint load too long");
	property p_load_off;
		load_start_sp_o |-> ##[0:2] time_event_o == '0;
	endproperty
	a_load_off: assert property (p_load_off) else $error("time events on after stop");
	property p_chain_pulse;
		chain_req_o |=> !chain_req_o;
	endproperty
	a_chain_pulse: assert property (p_chain_pulse) else $error("chain request too long");
	property p_chain_range;
		chain_req_o |-> chain_pattern_o inside {[3'h1:3'h4]};
	endproperty
	a_chain_range: assert property (p_chain_range) else $error("chain pattern out of range");
	property p_lamp_hold;
		$fell(hold_lamp_o) |-> quiet_ff < 4'hC;
	endproperty
	a_lamp_hold: assert property (p_lamp_hold) else $error("hold ended without release");
	property p_local_time;
		local_event_o != '0 && $past(local_event_o) != '0 |-> time_event_o == '0;
	endproperty
	a_local_time: assert property (p_local_time) else $error("time event on in local");
endmodule : seq_top_checker

bind seq_top seq_top_checker #(.TEV_N(TEV_N), .LEV_N(LEV_N), .TICK_CYCLES(TICK_CYCLES)) chk (
	.sys_clk_i(sys_clk_i), .reset_i(reset_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hsel_i(hsel_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .release_key_i(release_key_i),
	.release_contact_i(release_contact_i), .time_event_o(time_event_o),
	.local_event_o(local_event_o), .hold_lamp_o(hold_lamp_o),
	.load_start_sp_o(load_start_sp_o), .chain_pattern_o(chain_pattern_o),
	.chain_req_o(chain_req_o)
);
